// ===== stm_torque_mode_top.sv
// Torque-mode control selection core with Wishbone registers and interrupt
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "stm_defines.svh"

// How it works
// - Speed reached near selected speed command
// - Torque command full scale at 8 V
// - Equal selects or zero command: no torque
// - Signed offset within 999 mV added first
// - Torque capped by limit 1, analog cap ignored
// - Speed limit direction follows select inputs
// - Two selects: analog or limits 1-3
// - Three selects: analog or limits 1-7
// - Limiting flag when speed hits limit in torque mode
// - Code 0001 enters change mode, not absolute
// - Input off position, on speed control
// - Mode change accepted only at zero speed
// - Droop count cleared on change from position to speed control
// - Change at speed stays refused afterward
module stm_torque_mode_top (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Contact inputs
    input  wire logic              fwd_torque_select_i,
    input  wire logic              rev_torque_select_i,
    input  wire logic              speed_sel0_i,
    input  wire logic              speed_sel1_i,
    input  wire logic              speed_sel2_i,
    input  wire logic              mode_change_input_i,
    // Digitised analog inputs and feedback (same clock)
    input  wire stm_pkg::stm_val_t analog_torque_cmd_i,
    input  wire stm_pkg::stm_val_t analog_speed_cap_i,
    input  wire stm_pkg::stm_val_t analog_torque_cap_i,
    input  wire stm_pkg::stm_val_t motor_speed_i,
    input  wire stm_pkg::stm_val_t pos_speed_cmd_i,
    // Control outputs
    output stm_pkg::stm_val_t      torque_cmd_o,
    output stm_pkg::stm_val_t      speed_cap_o,
    output logic [1:0]             ctrl_mode_o,
    output logic                   droop_clear_o,
    // Status contacts and interrupt
    output logic                   speed_reached_o,
    output logic                   limiting_speed_flag_o,
    output logic                   zero_speed_flag_o,
    output logic                   irq_o
);
    stm_sel_if sel ();

    logic [5:0]              ctrl;
    logic [15:0]             tq_scale;
    stm_pkg::stm_val_t       tq_offset;
    logic [15:0]             tq_limit1;
    logic [15:0]             reach_band;
    logic [15:0]             zero_band;
    logic [15:0]             slim [1:7];
    logic [`STM_IRQ_W-1:0]   irq_stat;
    logic [`STM_IRQ_W-1:0]   irq_mask;
    stm_pkg::stm_mode_e      mode;
    logic                    blocked;
    logic                    prev_change;
    logic                    prev_reached;
    logic                    prev_limiting;
    logic                    mode_event;
    logic                    wr_stb;
    logic [31:0]             next_dat;
    logic [15:0]             cap_mag;
    logic                    cap_ccw;
    stm_pkg::stm_val_t       next_torque;
    stm_pkg::stm_val_t       next_offset;
    stm_pkg::stm_val_t       target_speed;
    logic [16:0]             adj_mv;
    logic [33:0]             tq_prod;
    logic [16:0]             tq_raw;
    logic                    change_mode_on;

    // Magnitude of a signed value, saturating the most negative code
    function automatic logic [15:0] stm_abs(input stm_pkg::stm_val_t v);
        return (v == 16'sh8000) ? 16'h7FFF : (v[15] ? 16'(-v) : 16'(v));
    endfunction : stm_abs

    // Merge written bytes into an old register value
    function automatic logic [31:0] stm_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : stm_merge

    stm_contact_dec u_dec (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .fwd_torque_select_i (fwd_torque_select_i),
        .rev_torque_select_i (rev_torque_select_i),
        .speed_sel0_i        (speed_sel0_i),
        .speed_sel1_i        (speed_sel1_i),
        .speed_sel2_i        (speed_sel2_i),
        .mode_change_input_i (mode_change_input_i),
        .sel                 (sel.dec)
    );

    assign sel.sp3_en     = ctrl[`STM_CTRL_SP3_BIT];
    // Absolute position detection locks the change mode out
    assign change_mode_on = (ctrl[`STM_CTRL_MODE_MSB:`STM_CTRL_MODE_LSB] == `STM_MODE_POS_SPEED)
                            && !ctrl[`STM_CTRL_ABS_BIT];

    // Bus handshake: one wait state, ack drops the cycle after it is given
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign next_offset = 16'(stm_merge(32'(tq_offset), wb_dat_i, wb_sel_i));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Parameter registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl       <= `STM_CTRL_RST;
            tq_scale   <= `STM_TQ_SCALE_RST;
            tq_offset  <= 16'sh0000;
            tq_limit1  <= `STM_TQ_LIMIT1_RST;
            reach_band <= `STM_REACH_BAND_RST;
            zero_band  <= `STM_ZERO_BAND_RST;
            irq_mask   <= '0;
            for (int i = 1; i <= 7; i++) begin
                slim[i] <= `STM_SLIM_RST;
            end
        end else if (wr_stb) begin
            case (wb_adr_i)
                `STM_REG_CTRL:       ctrl <= 6'(stm_merge(32'(ctrl), wb_dat_i, wb_sel_i));
                `STM_REG_TQ_SCALE:   tq_scale <= 16'(stm_merge(32'(tq_scale), wb_dat_i, wb_sel_i));
                `STM_REG_TQ_OFFSET: begin
                    // Offset held inside its allowed span
                    if (next_offset > `STM_OFFSET_MAX_MV) begin
                        tq_offset <= `STM_OFFSET_MAX_MV;
                    end else if (next_offset < `STM_OFFSET_MIN_MV) begin
                        tq_offset <= `STM_OFFSET_MIN_MV;
                    end else begin
                        tq_offset <= next_offset;
                    end
                end
                `STM_REG_TQ_LIMIT1:  tq_limit1 <= 16'(stm_merge(32'(tq_limit1), wb_dat_i, wb_sel_i));
                `STM_REG_REACH_BAND: reach_band <= 16'(stm_merge(32'(reach_band), wb_dat_i, wb_sel_i));
                `STM_REG_ZERO_BAND:  zero_band <= 16'(stm_merge(32'(zero_band), wb_dat_i, wb_sel_i));
                `STM_REG_IRQ_MASK:   irq_mask <= `STM_IRQ_W'(wb_dat_i);
                default: begin
                    if (wb_adr_i >= `STM_REG_SLIM_BASE && wb_adr_i <= `STM_REG_SLIM_LAST
                        && wb_adr_i[1:0] == 2'b00) begin
                        slim[3'((wb_adr_i - `STM_REG_SLIM_BASE) >> 2) + 3'h1] <=
                            16'(stm_merge(32'(slim[3'((wb_adr_i - `STM_REG_SLIM_BASE) >> 2)
                                                   + 3'h1]), wb_dat_i, wb_sel_i));
                    end
                end
            endcase
        end
    end

    // Read mux; unmapped offsets answer zero
    always_comb begin
        next_dat = 32'h0000_0000;
        case (wb_adr_i)
            `STM_REG_CTRL:       next_dat = 32'(ctrl);
            `STM_REG_TQ_SCALE:   next_dat = 32'(tq_scale);
            `STM_REG_TQ_OFFSET:  next_dat = {{16{tq_offset[15]}}, tq_offset};
            `STM_REG_TQ_LIMIT1:  next_dat = 32'(tq_limit1);
            `STM_REG_REACH_BAND: next_dat = 32'(reach_band);
            `STM_REG_ZERO_BAND:  next_dat = 32'(zero_band);
            `STM_REG_STATUS:     next_dat = 32'({blocked, 2'(mode), limiting_speed_flag_o,
                                                 speed_reached_o});
            `STM_REG_IRQ_STAT:   next_dat = 32'(irq_stat);
            `STM_REG_IRQ_MASK:   next_dat = 32'(irq_mask);
            default: begin
                if (wb_adr_i >= `STM_REG_SLIM_BASE && wb_adr_i <= `STM_REG_SLIM_LAST
                    && wb_adr_i[1:0] == 2'b00) begin
                    next_dat = 32'(slim[3'((wb_adr_i - `STM_REG_SLIM_BASE) >> 2) + 3'h1]);
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= next_dat;
        end
    end

    // Speed limit source and direction
    always_comb begin
        if (sel.limit_src == 3'h0) begin
            cap_mag = stm_abs(analog_speed_cap_i);
            cap_ccw = sel.dir_ccw ^ analog_speed_cap_i[15];
        end else begin
            cap_mag = slim[sel.limit_src];
            cap_ccw = sel.dir_ccw;
        end
    end

    // Torque path: offset, scale to full torque at 8 V, cap by limit 1, direction
    always_comb begin
        adj_mv  = 17'(analog_torque_cmd_i) + 17'(tq_offset);
        tq_prod = 34'(signed'(adj_mv)) * 34'(signed'({1'b0, tq_scale}));
        tq_raw  = 17'(signed'(tq_prod) / 34'(signed'(`STM_TQ_FULL_MV)));
        // The analog torque cap input is deliberately unused here
        if (signed'(tq_raw) > signed'({1'b0, tq_limit1})) begin
            next_torque = 16'(tq_limit1);
        end else if (signed'(tq_raw) < -signed'({1'b0, tq_limit1})) begin
            next_torque = 16'(-signed'({1'b0, tq_limit1}));
        end else begin
            next_torque = 16'(tq_raw);
        end
        if (!sel.dir_valid || adj_mv == 17'h00000) begin
            next_torque = 16'sh0000;
        end else if (!sel.dir_ccw) begin
            next_torque = 16'(-next_torque);
        end
        target_speed = cap_ccw ? signed'(cap_mag) : 16'(-signed'(cap_mag));
        if (mode == stm_pkg::STM_POSITION || mode == stm_pkg::STM_SPEED) begin
            target_speed = pos_speed_cmd_i;
        end
    end

    // Registered data outputs and status contacts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            torque_cmd_o          <= 16'sh0000;
            speed_cap_o           <= 16'sh0000;
            speed_reached_o       <= 1'b0;
            limiting_speed_flag_o <= 1'b0;
            zero_speed_flag_o     <= 1'b1;
        end else begin
            torque_cmd_o          <= (mode == stm_pkg::STM_TORQUE) ? next_torque : 16'sh0000;
            speed_cap_o           <= target_speed;
            speed_reached_o       <= stm_abs(16'(motor_speed_i - target_speed)) <= reach_band;
            limiting_speed_flag_o <= (mode == stm_pkg::STM_TORQUE)
                                     && (stm_abs(motor_speed_i) >= cap_mag);
            zero_speed_flag_o     <= stm_abs(motor_speed_i) <= zero_band;
        end
    end

    // Control mode; a change made away from zero speed stays refused until undone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode          <= stm_pkg::STM_TORQUE;
            blocked       <= 1'b0;
            prev_change   <= 1'b0;
            droop_clear_o <= 1'b0;
            mode_event    <= 1'b0;
        end else begin
            prev_change   <= sel.mode_change;
            droop_clear_o <= 1'b0;
            mode_event    <= 1'b0;
            if (!change_mode_on) begin
                mode    <= stm_pkg::STM_TORQUE;
                blocked <= 1'b0;
            end else if (mode == stm_pkg::STM_TORQUE) begin
                mode <= sel.mode_change ? stm_pkg::STM_SPEED : stm_pkg::STM_POSITION;
            end else if (sel.mode_change != prev_change && !zero_speed_flag_o) begin
                blocked <= !blocked;
            end else if (sel.mode_change != prev_change && zero_speed_flag_o && !blocked) begin
                mode       <= sel.mode_change ? stm_pkg::STM_SPEED : stm_pkg::STM_POSITION;
                mode_event <= 1'b1;
                if (sel.mode_change) begin
                    droop_clear_o <= 1'b1;
                end
            end else if (sel.mode_change != prev_change) begin
                blocked <= 1'b0;
            end
        end
    end

    // Sticky events; a new event wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat      <= '0;
            prev_reached  <= 1'b0;
            prev_limiting <= 1'b0;
        end else begin
            prev_reached  <= speed_reached_o;
            prev_limiting <= limiting_speed_flag_o;
            irq_stat <= (irq_stat & ~((wr_stb && wb_adr_i == `STM_REG_IRQ_STAT && wb_sel_i[0])
                                      ? `STM_IRQ_W'(wb_dat_i) : `STM_IRQ_W'(0)))
                        | {mode_event, limiting_speed_flag_o & ~prev_limiting,
                           speed_reached_o & ~prev_reached};
        end
    end

    assign irq_o       = |(irq_stat & irq_mask);
    assign ctrl_mode_o = 2'(mode);
endmodule : stm_torque_mode_top

// ===== stm_defines.svh
// Offsets, fields, reset values and limits of the torque-mode block
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

// Register byte offsets
`define STM_REG_CTRL        8'h00
`define STM_REG_TQ_SCALE    8'h04
`define STM_REG_TQ_OFFSET   8'h08
`define STM_REG_TQ_LIMIT1   8'h0C
`define STM_REG_REACH_BAND  8'h10
`define STM_REG_ZERO_BAND   8'h14
`define STM_REG_STATUS      8'h18
`define STM_REG_IRQ_STAT    8'h1C
`define STM_REG_IRQ_MASK    8'h20
`define STM_REG_SLIM_BASE   8'h24
`define STM_REG_SLIM_LAST   8'h3C

// Control register fields
`define STM_CTRL_MODE_LSB   0
`define STM_CTRL_MODE_MSB   3
`define STM_CTRL_ABS_BIT    4
`define STM_CTRL_SP3_BIT    5
`define STM_CTRL_RST        6'h00

// Control-mode code for position/speed change mode
`define STM_MODE_POS_SPEED  4'h1

// Status and interrupt bit positions
`define STM_ST_REACHED      0
`define STM_ST_LIMITING     1
`define STM_ST_MODE_LSB     2
`define STM_ST_BLOCKED      4
`define STM_IRQ_REACHED     0
`define STM_IRQ_LIMITING    1
`define STM_IRQ_MODE_CHG    2
`define STM_IRQ_W           3

// Analog command full scale in millivolts and offset bound
`define STM_TQ_FULL_MV      17'sh01F40
`define STM_OFFSET_MAX_MV   16'sh03E7
`define STM_OFFSET_MIN_MV   16'shFC19

// Reset values of the parameters
`define STM_TQ_SCALE_RST    16'h03E8
`define STM_TQ_LIMIT1_RST   16'h03E8
`define STM_REACH_BAND_RST  16'h0032
`define STM_ZERO_BAND_RST   16'h0032
`define STM_SLIM_RST        16'h0000

`endif

// ===== stm_pkg.sv
// Types shared by the torque-mode selection block
package stm_pkg;
    typedef enum logic [1:0] {
        STM_POSITION,
        STM_SPEED,
        STM_TORQUE
    } stm_mode_e;

    typedef logic signed [15:0] stm_val_t;
endpackage : stm_pkg

// ===== stm_sel_if.sv
// Synchronised contacts and decoded selections passed from the decoder to the core
`timescale 1ns/1ns
interface stm_sel_if;
    logic       fwd;          // Synchronised forward torque select
    logic       rev;          // Synchronised reverse torque select
    logic       mode_change;  // Synchronised mode-change input
    logic       sp3_en;       // Third speed select in use
    logic [2:0] limit_src;    // 0 = analog cap, 1..7 = internal limit
    logic       dir_valid;    // Exactly one direction select is on
    logic       dir_ccw;      // Positive command gives CCW

    modport dec  (input sp3_en, output fwd, rev, mode_change, limit_src, dir_valid, dir_ccw);
    modport core (output sp3_en, input fwd, rev, mode_change, limit_src, dir_valid, dir_ccw);
endinterface : stm_sel_if

// ===== stm_contact_dec.sv
// Contact input synchroniser and select decoder
`timescale 1ns/1ns
module stm_contact_dec (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Contact pins
    input  wire logic fwd_torque_select_i,
    input  wire logic rev_torque_select_i,
    input  wire logic speed_sel0_i,
    input  wire logic speed_sel1_i,
    input  wire logic speed_sel2_i,
    input  wire logic mode_change_input_i,
    // Decoded selections
    stm_sel_if.dec    sel
);
    logic [5:0] meta;
    logic [5:0] sync;

    // Two flops per contact; only the second stage is looked at
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 6'h00;
            sync <= 6'h00;
        end else begin
            meta <= {mode_change_input_i, speed_sel2_i, speed_sel1_i, speed_sel0_i,
                     rev_torque_select_i, fwd_torque_select_i};
            sync <= meta;
        end
    end

    // Selection decode from registered copies only
    always_comb begin
        sel.fwd         = sync[0];
        sel.rev         = sync[1];
        sel.mode_change = sync[5];
        sel.dir_valid   = sync[0] ^ sync[1];
        sel.dir_ccw     = sync[0] & ~sync[1];
        // Third select is ignored unless assigned, so a floating pin cannot move the limit
        if (sel.sp3_en) begin
            sel.limit_src = sync[4:2];
        end else begin
            sel.limit_src = {1'b0, sync[3:2]};
        end
    end
endmodule : stm_contact_dec

// ===== stm_torque_mode_chk.sv
// Assertion checker of the torque-mode top
`timescale 1ns/1ns
module stm_torque_mode_chk (
    // Clock, reset and bus handshake
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    // Contacts and feedback
    input wire logic              fwd_torque_select_i,
    input wire logic              rev_torque_select_i,
    input wire logic              mode_change_input_i,
    input wire stm_pkg::stm_val_t motor_speed_i,
    // Outputs watched
    input wire stm_pkg::stm_val_t torque_cmd_o,
    input wire stm_pkg::stm_val_t speed_cap_o,
    input wire logic [1:0]        ctrl_mode_o,
    input wire logic              droop_clear_o,
    input wire logic              speed_reached_o,
    input wire logic              limiting_speed_flag_o,
    input wire logic              zero_speed_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Mode one edge earlier
    logic [1:0] prev_mode;
    logic       to_spd;
    logic       to_pos;
    always_ff @(posedge clk_i) begin
        prev_mode <= ctrl_mode_o;
    end
    // Moves within change mode
    assign to_spd = (ctrl_mode_o == 2'h1) && (prev_mode == 2'h0);
    assign to_pos = (ctrl_mode_o == 2'h0) && (prev_mode == 2'h1);

    property p_ack_pulse;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_no_torque;
        (fwd_torque_select_i == rev_torque_select_i) [*5] |=> torque_cmd_o == 16'sh0000;
    endproperty
    property p_droop_entry;
        to_spd |-> droop_clear_o;
    endproperty
    property p_droop_only;
        droop_clear_o |-> to_spd;
    endproperty
    property p_spd_input;
        to_spd |-> $past(mode_change_input_i, 3);
    endproperty
    property p_pos_input;
        to_pos |-> !$past(mode_change_input_i, 3);
    endproperty
    property p_zero_gate;
        to_spd || to_pos |-> $past(zero_speed_flag_o);
    endproperty
    property p_zero_flag;
        (motor_speed_i == 16'sh0000) [*2] |=> zero_speed_flag_o;
    endproperty
    property p_reached;
        ($stable(motor_speed_i) && motor_speed_i == speed_cap_o) [*2] |-> speed_reached_o;
    endproperty
    property p_limit_mode;
        ctrl_mode_o != 2'h2 && prev_mode != 2'h2 |-> !limiting_speed_flag_o;
    endproperty

    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack not a one-cycle pulse");
    a_no_torque: assert property (p_no_torque)
        else $error("torque with equal selects");
    a_droop_entry: assert property (p_droop_entry)
        else $error("no droop clear on speed entry");
    a_droop_only: assert property (p_droop_only)
        else $error("stray droop clear");
    a_spd_input: assert property (p_spd_input)
        else $error("speed mode with input off");
    a_pos_input: assert property (p_pos_input)
        else $error("position mode with input on");
    a_zero_gate: assert property (p_zero_gate)
        else $error("mode change off zero speed");
    a_zero_flag: assert property (p_zero_flag)
        else $error("zero flag low at rest");
    a_reached: assert property (p_reached)
        else $error("reached low on target");
    a_limit_mode: assert property (p_limit_mode)
        else $error("limiting out of torque mode");

    // Main scenarios reached
    c_droop: cover property (droop_clear_o);
    c_limiting: cover property ($rose(limiting_speed_flag_o));
    c_reached: cover property ($rose(speed_reached_o));
endmodule : stm_torque_mode_chk

bind stm_torque_mode_top stm_torque_mode_chk chk_u (.*);

// ===== stm_host_model.sv
// Host sequencer model driving the contact inputs
`timescale 1ns/1ns
module stm_host_model (
    // Clock and standstill status
    input  wire logic       clk_i,
    input  wire logic       zero_speed_i,
    // Wanted contacts {mode, sel2, sel1, sel0, rev, fwd} and override
    input  wire logic [5:0] want_i,
    input  wire logic       force_i,
    // Contact levels
    output logic [5:0]      contact_o = 6'h00
);
    // Contacts move just after an edge
    always_ff @(posedge clk_i) begin
        contact_o[4:0] <= want_i[4:0];
        // Mode contact waits for standstill unless forced
        if (zero_speed_i || force_i) begin
            contact_o[5] <= want_i[5];
        end
    end
endmodule : stm_host_model

// ===== tb_top.sv
// Self-checking testbench of the torque-mode top
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, force_m = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat_w = 32'h0, dat_r, q;
    logic [5:0]  want = 6'h00, cont;
    stm_pkg::stm_val_t tq_in = 0, sp_in = 0, tq_cap = 0, motor = 0, pos_cmd = 0;
    stm_pkg::stm_val_t torque, cap;
    logic [1:0]  mode;
    logic        droop, reached, limiting, zero, irq;
    int          errors = 0, total_checks = 0, sel, e;
    logic [7:0]  r_adr [7] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h24, 8'h40};
    logic [15:0] r_val [7] = '{16'h0, 16'h03E8, 16'h03E8, 16'h0032, 16'h0032, 16'h0, 16'h0};
    logic [15:0] t_exp [4] = '{16'h0000, 16'h01F4, 16'hFE0C, 16'h0000};

    // 125 MHz clock
    always #4 clk = ~clk;

    stm_host_model host_u (.clk_i(clk), .zero_speed_i(zero), .want_i(want), .force_i(force_m),
        .contact_o(cont));
    stm_torque_mode_top dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .fwd_torque_select_i(cont[0]), .rev_torque_select_i(cont[1]),
        .speed_sel0_i(cont[2]), .speed_sel1_i(cont[3]), .speed_sel2_i(cont[4]),
        .mode_change_input_i(cont[5]), .analog_torque_cmd_i(tq_in), .analog_speed_cap_i(sp_in),
        .analog_torque_cap_i(tq_cap), .motor_speed_i(motor), .pos_speed_cmd_i(pos_cmd),
        .torque_cmd_o(torque), .speed_cap_o(cap), .ctrl_mode_o(mode), .droop_clear_o(droop),
        .speed_reached_o(reached), .limiting_speed_flag_o(limiting),
        .zero_speed_flag_o(zero), .irq_o(irq));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (ack !== 1'b1) errors++;
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog far beyond the few hundred cycles needed
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end

    initial begin
        tick(6);
        rst <= 1'b0;
        // Reset values and an unmapped word
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, r_adr[i], 32'h0);
            check("reset value", q[15:0], r_val[i]);
        end
        check("reset mode", 16'(mode), 16'h0002);
        $display("test reset done");
        // Direction table at 4000 mV, scale 1000
        tq_in <= 16'sh0FA0;
        for (int i = 0; i < 4; i++) begin
            want <= 6'(i);
            tick(6);
            check("torque dir", torque, t_exp[i]);
        end
        tq_in <= 16'sh0000;
        want <= 6'h01;
        tick(6);
        check("torque zero cmd", torque, 16'h0000);
        // Offset writes are clamped
        wb(1'b1, 8'h08, 32'h07D0);
        wb(1'b0, 8'h08, 32'h0);
        check("offset high", q[15:0], 16'h03E7);
        tq_in <= 16'sh0001;
        tick(6);
        check("torque offset", torque, 16'h007D);
        wb(1'b1, 8'h08, 32'hFFFFF830);
        wb(1'b0, 8'h08, 32'h0);
        check("offset low", q[15:0], 16'hFC19);
        wb(1'b1, 8'h08, 32'h0);
        tq_in <= 16'sh0FA0;
        wb(1'b1, 8'h04, 32'h07D0);
        tick(6);
        check("torque scale", torque, 16'h03E8);
        wb(1'b1, 8'h0C, 32'h012C);
        tq_cap <= 16'sh7FFF;
        tick(6);
        check("torque cap", torque, 16'h012C);
        tq_cap <= 16'sh0000;
        tick(6);
        check("torque cap", torque, 16'h012C);
        $display("test torque done");
        // Internal limits set to 256 times their number; the motor later reaches limit 5
        for (int i = 1; i < 8; i++) wb(1'b1, 8'h24 + 8'(4 * (i - 1)), 32'(256 * i));
        sp_in <= 16'sh0050;
        for (int k = 0; k < 16; k++) begin
            if (k == 8) wb(1'b1, 8'h00, 32'h20);
            want <= {1'b0, 3'(k), 2'b01};
            tick(6);
            sel = (k > 7) ? (k % 8) : (k % 4);
            e = (sel == 0) ? 80 : 256 * sel;
            check("speed cap", cap, 16'(e));
        end
        want <= 6'h02;
        tick(6);
        check("cap reversed", cap, 16'hFFB0);
        want <= 6'h16;
        tick(6);
        check("cap reversed", cap, 16'hFB00);
        $display("test speed limit done");
        // Limiting, reached and interrupt
        want <= 6'h15;
        wb(1'b1, 8'h20, 32'h2);
        motor <= 16'sh0500;
        tick(6);
        check("limiting", 16'(limiting), 16'h0001);
        check("reached", 16'(reached), 16'h0001);
        motor <= 16'sh0100;
        tick(6);
        check("limiting", 16'(limiting), 16'h0000);
        check("irq sticky", 16'(irq), 16'h0001);
        wb(1'b0, 8'h1C, 32'h0);
        check("irq stat", q[15:0] & 16'h0002, 16'h0002);
        wb(1'b1, 8'h1C, 32'h7);
        wb(1'b1, 8'h20, 32'h0);
        motor <= 16'sh0500;
        tick(6);
        check("irq masked", 16'(irq), 16'h0000);
        motor <= 16'sh0000;
        $display("test flags done");
        // Position/speed change mode
        wb(1'b1, 8'h00, 32'h01);
        want <= 6'h00;
        tick(6);
        check("mode pos", 16'(mode), 16'h0000);
        want <= 6'h20;
        tick(6);
        check("mode spd", 16'(mode), 16'h0001);
        force_m <= 1'b1;
        motor <= 16'sh0200;
        tick(4);
        want <= 6'h00;
        tick(6);
        check("mode kept", 16'(mode), 16'h0001);
        wb(1'b0, 8'h18, 32'h0);
        check("blocked", q[15:0] & 16'h0010, 16'h0010);
        motor <= 16'sh0000;
        tick(6);
        check("mode kept", 16'(mode), 16'h0001);
        want <= 6'h20;
        tick(6);
        want <= 6'h00;
        tick(6);
        check("mode pos", 16'(mode), 16'h0000);
        force_m <= 1'b0;
        wb(1'b1, 8'h00, 32'h11);
        tick(3);
        check("mode abs", 16'(mode), 16'h0002);
        $display("test change mode done");
        report_and_stop();
    end
endmodule : tb_top
